// ---- rtl/rcb_pkg.sv ----
package rcb_pkg;

  // ----------------------------------------------------------------
  // bus widths and timing
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W       = 8;        // register address width
  localparam int unsigned DATA_W       = 8;        // register data width
  localparam int unsigned CLK_HZ       = 20000000; // system clock rate
  localparam int unsigned SETUP_NS     = 20;       // address/data valid after select falls
  // cycles to wait after select falls before sampling; least time rounds up
  localparam int unsigned SETUP_CYC_RAW = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned SETUP_CYC    = (SETUP_CYC_RAW < 1) ? 1 : SETUP_CYC_RAW;
  localparam logic [1:0]  SETUP_CNT    = 2'(SETUP_CYC);
  localparam int unsigned NUM_REGS     = 16;       // implemented register count
  localparam logic [7:0]  REG_RST      = 8'h00;    // reset value of each register
  localparam logic [7:0]  UNMAPPED_RD  = 8'h00;    // read answer above the implemented range
  localparam logic        PARITY_EN    = 1'b0;     // parity disabled in this configuration

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  // processor side request pins
  typedef struct packed {
    logic              sel_n;   // active-low chip select
    logic              rd_wr;   // 1 = read, 0 = write
    logic [ADDR_W-1:0] addr;    // register address
    logic [DATA_W-1:0] wdata;   // data bus level seen by the device
  } rcb_req_t;

  // device side open-drain and data-drive pins
  typedef struct packed {
    logic              ack_oe;  // high pulls acknowledge low
    logic              irq_oe;  // high pulls interrupt low
    logic              data_oe; // high drives data bus
    logic [DATA_W-1:0] rdata;   // data driven on reads
  } rcb_rsp_t;

  // port states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_ACK   = 4'b0100,
    ST_DONE  = 4'b1000
  } rcb_state_t;

  // in-range decode of an address, used for writes and reads
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    return a < ADDR_W'(NUM_REGS);
  endfunction

endpackage

// ---- rtl/rcb_port.sv ----
`timescale 1ns/1ns
// Operation
// - 8-bit address, 8-bit bidirectional data
// - read/write, select, acknowledge, shared interrupt
// - no parity generated or checked
// - acknowledge and interrupt driven open-drain
// - acknowledge only after data valid or latched
// - release acknowledge before next cycle begins
module rcb_port
  import rcb_pkg::*;
(
  input  wire logic              sys_clk_i,   // system clock
  input  wire logic              reset_n_i,   // async reset, active low
  input  wire rcb_req_t          req_i,       // processor pins
  input  wire logic              event_i,     // internal event raising interrupt
  input  wire logic              irq_clr_i,   // internal clear of pending interrupt
  output rcb_rsp_t               rsp_o        // open-drain and data drive
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rcb_state_t          state_r;                    // port state
  logic [1:0]          setup_r;                    // setup wait counter
  logic [DATA_W-1:0]   regs_r [NUM_REGS];          // register storage
  logic [DATA_W-1:0]   rdata_r;                    // read data held on bus
  logic                data_oe_r;                  // data bus drive
  logic                ack_oe_r;                   // acknowledge pull-down
  logic                irq_r;                      // pending interrupt
  logic [3:0]          idx;                        // register index
  logic                sample_now;                 // address, direction and data taken now

  // low bits pick the register; the range test is done apart by reg_hit
  assign idx = req_i.addr[3:0];

  // the one edge of a cycle at which the bus lines are trusted
  assign sample_now = (state_r == ST_SETUP) && !req_i.sel_n && (setup_r <= 2'h1);

  // ----------------------------------------------------------------
  // usage notes
  // ----------------------------------------------------------------
  // select is taken as already synchronous to the system clock; a
  // select from another clock domain needs two flops in front of it
  // the setup wait covers the time the processor has to settle the
  // address, direction and write data after select falls
  // a cycle given up before the sample point changes no register
  // addresses at or above the register count are acknowledged, but
  // writes there are dropped and reads there return a fixed value
  // acknowledge stays pulled while select stays low, so the processor
  // may add as many wait states as it needs
  // acknowledge and data drive drop at the first edge that sees select
  // high, so the shared lines are free before another cycle can start
  // the bus has no parity bit here: none is made and none is checked

  // ----------------------------------------------------------------
  // handshake state machine
  // ----------------------------------------------------------------
  // select low starts a cycle; sample after setup time, then acknowledge
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      setup_r <= 2'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!req_i.sel_n) begin
            state_r <= ST_SETUP;
            setup_r <= SETUP_CNT;
          end
        end
        ST_SETUP: begin
          if (req_i.sel_n) begin
            state_r <= ST_IDLE;                    // aborted cycle
          end else if (setup_r <= 2'h1) begin
            state_r <= ST_ACK;
          end else begin
            setup_r <= setup_r - 2'h1;
          end
        end
        ST_ACK: begin
          if (req_i.sel_n) begin
            state_r <= ST_IDLE;
          end else begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (req_i.sel_n) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // register write and read capture
  // ----------------------------------------------------------------
  // data is latched at the sample point, before acknowledge is raised
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RST;
      end
      rdata_r <= REG_RST;
    end else if (sample_now) begin
      // writes outside the implemented range fall away
      if (!req_i.rd_wr && reg_hit(req_i.addr)) begin
        regs_r[idx] <= req_i.wdata;
      end
      // reads capture now so data is settled before acknowledge
      if (req_i.rd_wr) begin
        rdata_r <= reg_hit(req_i.addr) ? regs_r[idx] : UNMAPPED_RD;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drives
  // ----------------------------------------------------------------
  // acknowledge follows valid data; released as soon as select rises
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_oe_r  <= 1'b0;
      data_oe_r <= 1'b0;
    end else begin
      ack_oe_r  <= !req_i.sel_n && (state_r == ST_ACK || state_r == ST_DONE);
      data_oe_r <= !req_i.sel_n && req_i.rd_wr && (state_r != ST_IDLE) && (state_r != ST_SETUP);
    end
  end

  // shared interrupt, pulled low while pending; set wins over clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_r <= 1'b0;
    end else if (event_i) begin
      irq_r <= 1'b1;
    end else if (irq_clr_i) begin
      irq_r <= 1'b0;
    end
  end

  // no parity pin exists: generation and checking are absent
  assign rsp_o.ack_oe  = ack_oe_r;
  assign rsp_o.irq_oe  = irq_r;
  assign rsp_o.data_oe = data_oe_r;
  assign rsp_o.rdata   = rdata_r;

  // ----------------------------------------------------------------
  // handshake and interrupt assertions
  // ----------------------------------------------------------------
  // acknowledge may only rise while the processor holds select low
  AST_ACK_NEEDS_SEL: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(ack_oe_r) |-> !$past(req_i.sel_n))
    else $error("acknowledge raised without select");
  AST_ACK_RELEASE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    req_i.sel_n |=> !ack_oe_r)
    else $error("acknowledge not released after select rose");
  AST_ACK_AFTER_SETUP: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(ack_oe_r) |-> $past(state_r) == ST_ACK || $past(state_r) == ST_DONE)
    else $error("acknowledge before data sampled");
  AST_ACK_DELAY: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state_r == ST_IDLE && !req_i.sel_n) ##1 !req_i.sel_n [*3] |=> ack_oe_r)
    else $error("acknowledge late");
  AST_RD_DATA_WITH_ACK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (ack_oe_r && req_i.rd_wr && !req_i.sel_n && $stable(req_i.rd_wr)) |-> data_oe_r)
    else $error("acknowledge on read without data drive");
  AST_WR_LATCHED: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    (state_r == ST_SETUP && setup_r <= 2'h1 && !req_i.sel_n && !req_i.rd_wr && req_i.addr == 8'h00)
    |=> regs_r[0] == $past(req_i.wdata))
    else $error("write data not latched");
  AST_IRQ_SET: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    event_i |=> irq_r)
    else $error("event did not raise interrupt");
  // a clear with no event drops the pending interrupt
  AST_IRQ_CLEAR: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    irq_clr_i && !event_i |=> !irq_r)
    else $error("interrupt not cleared");
  // with neither event nor clear the pending state holds
  AST_IRQ_HOLD: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !event_i && !irq_clr_i |=> $stable(irq_r))
    else $error("interrupt changed with no cause");
  AST_NO_DATA_ON_WRITE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !$past(req_i.rd_wr) && $past(state_r) != ST_IDLE |-> !data_oe_r)
    else $error("data driven during write");
  // data drive only answers a read that was selected one edge before
  AST_DATA_ONLY_READ: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    data_oe_r |-> $past(req_i.rd_wr) && !$past(req_i.sel_n))
    else $error("data driven outside a read");
  // a held acknowledge belongs to a cycle that has reached its last state
  AST_ACK_STATE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ack_oe_r |-> state_r == ST_DONE)
    else $error("acknowledge outside the answer state");
  // once sampled, a cycle still selected is answered at the next edge
  AST_SAMPLE_TO_ACK: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    sample_now ##1 !req_i.sel_n |=> ack_oe_r)
    else $error("sampled cycle not acknowledged");
  // read data may not move while acknowledge is held
  AST_RDATA_STABLE: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ack_oe_r && $past(ack_oe_r) |-> $stable(rdata_r))
    else $error("read data changed under acknowledge");

  // ----------------------------------------------------------------
  // coverage of the main scenarios
  // ----------------------------------------------------------------
  // a read answered
  COV_READ: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ack_oe_r && req_i.rd_wr);
  COV_WRITE: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ack_oe_r && !req_i.rd_wr);
  COV_ABORT: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_r == ST_SETUP && req_i.sel_n);
  COV_IRQ: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    event_i && irq_clr_i);
  // acknowledge held for a second edge while select stays low
  COV_WAIT: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    ack_oe_r && $past(ack_oe_r));

endmodule // rcb_port

// ---- testbench/rcb_host_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// processor model driving the control bus
// ----------------------------------------------------------------
module rcb_host_model
  import rcb_pkg::*;
(
  input  wire logic              clk_i,   // system clock
  input  wire logic              ack_n_i, // resolved acknowledge line
  input  wire logic [DATA_W-1:0] data_i,  // resolved data bus
  output rcb_req_t               req_o    // processor pins
);
  initial req_o = '{sel_n: 1'b1, rd_wr: 1'b1, addr: 8'h00, wdata: 8'h00};

  // full transfer: select, then wait states until acknowledge is seen
  task automatic xfer(input logic rd, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q, output int n);
    n = 0;
    req_o <= '{sel_n: 1'b0, rd_wr: rd, addr: a, wdata: d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_n_i !== 1'b0 && n < 20);
    q = data_i;
    // released lines move off their last value
    req_o <= '{sel_n: 1'b1, rd_wr: ~rd, addr: ~a, wdata: ~d};
    @(posedge clk_i);
  endtask

  // select dropped after one edge, before any answer
  task automatic abort(input logic [ADDR_W-1:0] a);
    req_o <= '{sel_n: 1'b0, rd_wr: 1'b0, addr: a, wdata: 8'hAA};
    @(posedge clk_i);
    req_o <= '{sel_n: 1'b1, rd_wr: 1'b1, addr: ~a, wdata: 8'h55};
  endtask
endmodule // rcb_host_model

// ---- testbench/ring_chipset_control_bus_port_test.sv ----
`timescale 1ns/1ns
module ring_chipset_control_bus_port_test;
  import rcb_pkg::*;
  logic              sys_clk_i = 1'b0; // 20 MHz clock
  logic              reset_n_i = 1'b0; // async reset
  logic              event_i   = 1'b0; // interrupt source
  logic              irq_clr_i = 1'b0; // interrupt clear
  rcb_req_t          host_req;         // pins from processor
  rcb_req_t          req;              // pins as the device sees them
  rcb_rsp_t          rsp;              // device drive
  logic [DATA_W-1:0] q;                // captured data
  int                n;                // edges waited for acknowledge
  int                num_errors  = 0;
  int                comparisons = 0;
  int                cycles      = 0;
  wire               ack_n = ~rsp.ack_oe; // pull-up unless pulled low
  wire               irq_n = ~rsp.irq_oe; // pull-up unless pulled low
  // ----------------------------------------------------------------
  // bus resolution and instances
  // ----------------------------------------------------------------
  always_comb begin
    req       = host_req;
    req.wdata = rsp.data_oe ? rsp.rdata : host_req.wdata;
  end
  rcb_port rcb_port_i (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .req_i(req),
                       .event_i(event_i), .irq_clr_i(irq_clr_i), .rsp_o(rsp));
  rcb_host_model rcb_host_model_i (.clk_i(sys_clk_i), .ack_n_i(ack_n), .data_i(req.wdata), .req_o(host_req));
  initial begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  // hang guard: the scenarios need about seventy-five cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // compare and report
  // ----------------------------------------------------------------
  // data bus values
  task automatic check_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t data %h expected %h", $time, got, exp);
    end
  endtask
  // edge counts of a handshake
  task automatic check_cycles(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      num_errors++;
      $display("[FAIL] %0t cycles %0d expected %0d", $time, got, exp);
    end
  endtask
  // single pin levels
  task automatic check_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // writes then reads at both ends of the map and beyond it
  task automatic t_regs();
    logic [ADDR_W-1:0] ad [4] = '{8'h00, 8'h0F, 8'h10, 8'hFF};
    foreach (ad[i]) begin
      rcb_host_model_i.xfer(1'b0, ad[i], 8'hA5 ^ ad[i], q, n);
      check_cycles(n, SETUP_CYC + 3);
    end
    foreach (ad[i]) begin
      rcb_host_model_i.xfer(1'b1, ad[i], 8'h3C, q, n);
      check_cycles(n, SETUP_CYC + 3);
      check_data(q, (ad[i] < ADDR_W'(NUM_REGS)) ? (8'hA5 ^ ad[i]) : UNMAPPED_RD);
    end
  endtask
  // select raised early: acknowledge stays released and nothing is written
  task automatic t_abort();
    rcb_host_model_i.abort(8'h03);
    repeat (5) begin
      @(posedge sys_clk_i);
      check_pin(ack_n, 1'b1);
    end
    rcb_host_model_i.xfer(1'b1, 8'h03, 8'h3C, q, n);
    check_data(q, REG_RST);
  endtask
  // interrupt set, held, cleared, set wins over clear
  task automatic t_irq(input logic ev, input logic clr, input logic exp);
    event_i   <= ev;
    irq_clr_i <= clr;
    @(posedge sys_clk_i);
    event_i   <= 1'b0;
    irq_clr_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    check_pin(irq_n, exp);
  endtask
  // reset in mid-run: pins drop at once, storage returns to its reset value
  task automatic t_reset();
    reset_n_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    check_pin(rsp.ack_oe, 1'b0);
    check_pin(rsp.irq_oe, 1'b0);
    check_pin(rsp.data_oe, 1'b0);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rcb_host_model_i.xfer(1'b1, 8'h00, 8'h3C, q, n);
    check_cycles(n, SETUP_CYC + 3);
    check_data(q, REG_RST);
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_i);
    check_pin(rsp.ack_oe, 1'b0);
    check_pin(rsp.irq_oe, 1'b0);
    check_pin(rsp.data_oe, 1'b0);
    check_data(rsp.rdata, REG_RST);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    t_regs();
    t_abort();
    t_irq(1'b1, 1'b0, 1'b0);
    t_irq(1'b0, 1'b1, 1'b1);
    t_irq(1'b1, 1'b1, 1'b0);
    t_reset();
    report_and_stop();
  end
endmodule // ring_chipset_control_bus_port_test
